// ---- common/src_pkg.sv ----
// Package: constants, types and decoding shared by the reset combiner
package src_pkg;

   // -----------------------------------------------------------------
   // Reset cause register layout
   // -----------------------------------------------------------------
   localparam int CAUSE_W = 9;
   localparam int CAUSE_POR = 0;
   localparam int CAUSE_BROWNOUT = 1;
   localparam int CAUSE_PIN = 2;
   localparam int CAUSE_SWI = 3;
   localparam int CAUSE_WATCHDOG = 4;
   localparam int CAUSE_CFG = 5;
   localparam int CAUSE_TRAP = 6;
   localparam int CAUSE_IOP = 7;
   localparam int CAUSE_UNINIT = 8;
   localparam logic [8:0] CAUSE_POR_VALUE = 9'h003;
   localparam logic [8:0] CAUSE_NONE = 9'h000;
   localparam logic SYS_RESET_AT_POR = 1'h1;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   // Member order matches the cause bit positions, MSB first
   typedef struct packed {
      logic uninit_wreg_reset;
      logic illegal_opcode_reset;
      logic trap_conflict_reset;
      logic config_mismatch_reset;
      logic watchdog_timeout_reset;
      logic software_reset_instruction;
      logic external_clear_pin;
      logic brownout_reset;
      logic power_on;
   } src_sources_s;

   typedef struct packed {
      logic wr_en;
      logic [8:0] data;
   } src_cause_wr_s;

   typedef struct packed {
      logic sys_reset;
      logic [8:0] cause;
   } src_main_state_s;

   typedef enum logic [1:0] {CLK_HOLD, CLK_WAIT, CLK_RUN} src_clk_state_e;

   typedef struct packed {
      logic fetch_enable;
      logic rc_osc_select;
      logic clock_fail_event;
   } src_clk_status_s;

   typedef struct packed {
      src_clk_state_e state;
      src_clk_status_s status;
   } src_clk_state_s;

   // -----------------------------------------------------------------
   // Decoding
   // -----------------------------------------------------------------
   // Active sources as a cause vector, bit n for cause n
   function automatic logic [8:0] src_cause_bits(input src_sources_s s);
      src_cause_bits = s;
   endfunction : src_cause_bits

endpackage : src_pkg

// ---- rtl/src_clock_guard.sv ----
// Module: gates instruction fetch on a valid clock and runs clock checks
`timescale 1ns/100ps
`default_nettype none
module src_clock_guard
   import src_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic sys_reset,
   input wire logic fail_monitor_en,
   input wire logic primary_clock_ok,
   input wire logic clock_valid,
   input wire logic crystal_select_req,
   output src_clk_status_s status
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   src_clk_state_s state_ff;
   src_clk_state_s nxt_state;
   logic clock_bad;

   assign clock_bad = fail_monitor_en & ~primary_clock_ok;

   // Next state: hold during reset, wait for clock, then run
   always_comb begin
      nxt_state = state_ff;
      nxt_state.status.clock_fail_event = 1'h0;
      case (state_ff.state)
         CLK_HOLD: begin
            nxt_state.status.fetch_enable = 1'h0;
            if (!sys_reset) begin
               // Check starts exactly as reset lets go
               if (clock_bad) begin
                  nxt_state.status.rc_osc_select = 1'h1;
                  nxt_state.status.clock_fail_event = 1'h1;
               end
               nxt_state.state = CLK_WAIT;
            end
         end
         CLK_WAIT: begin
            // No fetch until a clock source has been released
            if (clock_valid) begin
               nxt_state.status.fetch_enable = 1'h1;
               nxt_state.state = CLK_RUN;
            end
         end
         CLK_RUN: begin
            // A failure while running also falls back to the RC clock
            if (clock_bad && !state_ff.status.rc_osc_select) begin
               nxt_state.status.rc_osc_select = 1'h1;
               nxt_state.status.clock_fail_event = 1'h1;
            end else if (crystal_select_req) begin
               // Trap handler picks the crystal again
               nxt_state.status.rc_osc_select = 1'h0;
            end
         end
         default: begin
            nxt_state.state = CLK_HOLD;
         end
      endcase
      // Any reset stops fetching at once
      if (sys_reset) begin
         nxt_state.state = CLK_HOLD;
         nxt_state.status.fetch_enable = 1'h0;
      end
   end

   // Register, frozen while the clock enable is low
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= '{state: CLK_HOLD, status: '0};
      end else if (clk_en) begin
         state_ff <= nxt_state;
      end
   end

   assign status = state_ff.status;

endmodule : src_clock_guard
`default_nettype wire

// ---- rtl/src_reset_combiner.sv ----
// Module: system reset combiner with sticky reset cause register
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - The system reset line is high whenever any reset source is active.
// - Nine sources feed it: power-on, pin, instruction, watchdog, brown-out, configuration mismatch, trap conflict, illegal opcode, uninitialised W.
// - Each reset kind sets its own bit in the reset cause register.
// - Power-on clears all cause bits but sets the power-on and brown-out bits 0 and 1.
// - Software may write any cause bit to one or zero unless the power-on source is active; a source active in the same cycle keeps its bit set over a write.
// - A software write to a cause bit only stores it and never starts a reset.
// - Storage with no defined reset value is unknown at power-on and kept through all other resets.
// - Reset release does not wait for the oscillator, its start-up timer or PLL lock.
// - After release, fetch waits until a valid clock has been released.
// - The clock monitor, when enabled, starts checking as reset is released.
// - With the primary clock not ok at that moment the device falls back to the fast RC clock; the trap handler may pick the crystal.
// - The cause register reset value depends on the kind of reset.
module src_reset_combiner
   import src_pkg::*;
#(
   parameter int RETAIN_W = 16
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire src_sources_s sources,
   input wire src_cause_wr_s cause_wr,
   input wire logic retain_wr_en,
   input wire logic [RETAIN_W-1:0] retain_wr_data,
   input wire logic fail_monitor_en,
   input wire logic primary_clock_ok,
   input wire logic clock_valid,
   input wire logic crystal_select_req,
   output logic system_reset_line,
   output logic [CAUSE_W-1:0] reset_cause_register,
   output logic [CAUSE_W-1:0] sources_active,
   output logic [RETAIN_W-1:0] retain_rd_data,
   output src_clk_status_s clk_status
);

   // -----------------------------------------------------------------
   // Source decode
   // -----------------------------------------------------------------
   src_main_state_s state_ff;
   src_main_state_s nxt_state;
   logic [CAUSE_W-1:0] active_ff;
   logic [CAUSE_W-1:0] nxt_active;
   logic [CAUSE_W-1:0] raw_causes;
   logic any_source;

   // The asynchronous reset is the root power-on source; the synchronous
   // power_on member covers a detector that fires with the clock running
   assign raw_causes = src_cause_bits(sources);
   assign any_source = |raw_causes;

   // -----------------------------------------------------------------
   // Reset line and cause register
   // -----------------------------------------------------------------
   // Only the sources steer the line; oscillator and PLL start-up are
   // tracked by the clock guard so release is never held off by them
   always_comb begin
      nxt_state = state_ff;
      // Line follows the OR of all sources and drops only when all
      // of them are gone
      nxt_state.sys_reset = any_source;
      // Software write lands first so a source in the same cycle still
      // sets its bit; a set bit never feeds back into the line
      if (cause_wr.wr_en) begin
         nxt_state.cause = cause_wr.data;
      end
      // Sticky set per source, the set wins over a write
      nxt_state.cause = nxt_state.cause | raw_causes;
      // Power-on redefines the whole register
      if (sources.power_on) begin
         nxt_state.cause = CAUSE_POR_VALUE | raw_causes;
      end
   end

   // Cause value at power-on differs from every other reset kind
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff.sys_reset <= SYS_RESET_AT_POR;
         state_ff.cause <= CAUSE_POR_VALUE;
      end else if (clk_en) begin
         state_ff <= nxt_state;
      end
   end

   // -----------------------------------------------------------------
   // Live source view
   // -----------------------------------------------------------------
   // Lets software see which sources are still holding the line
   assign nxt_active = raw_causes;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         active_ff <= CAUSE_NONE;
      end else if (clk_en) begin
         active_ff <= nxt_active;
      end
   end

   // -----------------------------------------------------------------
   // Retained storage
   // -----------------------------------------------------------------
   // Deliberately has no reset: its content is unknown after power-up
   // and survives every other reset, so software can keep state there
   logic [RETAIN_W-1:0] retain_ff;

   always_ff @(posedge core_clk) begin
      if (clk_en && retain_wr_en) begin
         retain_ff <= retain_wr_data;
      end
   end

   // -----------------------------------------------------------------
   // Clock guard
   // -----------------------------------------------------------------
   // Fetch gating and clock monitor sit after the reset line, so a
   // slow crystal delays code execution, not the reset release
   src_clock_guard u_clock_guard (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .sys_reset(state_ff.sys_reset),
      .fail_monitor_en(fail_monitor_en),
      .primary_clock_ok(primary_clock_ok),
      .clock_valid(clock_valid),
      .crystal_select_req(crystal_select_req),
      .status(clk_status)
   );

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign system_reset_line = state_ff.sys_reset;
   assign reset_cause_register = state_ff.cause;
   assign sources_active = active_ff;
   assign retain_rd_data = retain_ff;

endmodule : src_reset_combiner
`default_nettype wire

// ---- sim/src_clock_model.sv ----
// Partner: clock system start-up as seen by the reset combiner
`timescale 1ns/100ps
`default_nettype none
module src_clock_model #(
   parameter int VALID_CYC = 12,
   parameter int XTAL_CYC = 40
) (
   input wire logic core_clk,
   input wire logic reset_n,
   output logic clock_valid,
   output logic primary_clock_ok
);
   int cyc_cnt_ff;
   // Timers restart on reset_n and ignore the system reset line entirely
   always @(negedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cyc_cnt_ff <= 0;
      end else if (cyc_cnt_ff < XTAL_CYC) begin
         cyc_cnt_ff <= cyc_cnt_ff + 1;
      end
   end
   // Fast RC is ready early; a slow crystal far later
   assign clock_valid = cyc_cnt_ff >= VALID_CYC;
   assign primary_clock_ok = cyc_cnt_ff >= XTAL_CYC;
endmodule : src_clock_model
`default_nettype wire

// ---- sim/src_reset_combiner_properties.sv ----
// Checker: timing relations at the reset combiner ports
`timescale 1ns/100ps
`default_nettype none
module src_reset_combiner_properties
   import src_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire src_sources_s sources,
   input wire src_cause_wr_s cause_wr,
   input wire logic fail_monitor_en,
   input wire logic primary_clock_ok,
   input wire logic system_reset_line,
   input wire logic [CAUSE_W-1:0] reset_cause_register,
   input wire src_clk_status_s clk_status
);
   // All checks live in the one clock domain
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   a_line_set: assert property (clk_en && sources != '0
      |=> system_reset_line) else $error("line low with a source");
   a_line_clear: assert property (clk_en && sources == '0
      |=> !system_reset_line) else $error("line high with no source");
   a_cause_sets: assert property (clk_en |=>
      (reset_cause_register & $past(sources)) == $past(sources))
      else $error("active source left its cause bit clear");
   a_write_value: assert property (clk_en && cause_wr.wr_en
      && sources == '0 |=> reset_cause_register == $past(cause_wr.data))
      else $error("cause write not stored");
   a_write_no_rst: assert property (cause_wr.wr_en && clk_en
      && sources == '0 |=> !system_reset_line)
      else $error("cause write started a reset");
   a_cause_sticky: assert property (clk_en && !cause_wr.wr_en
      && sources == '0 |=> $stable(reset_cause_register))
      else $error("cause bits moved on their own");
   a_por_value: assert property (clk_en && sources.power_on
      |=> reset_cause_register == (CAUSE_POR_VALUE | $past(sources)))
      else $error("power-on cause value wrong");
   a_fetch_off: assert property (clk_en && system_reset_line
      |=> !clk_status.fetch_enable) else $error("fetch during reset");
   a_fail_start: assert property ($past(system_reset_line)
      && !system_reset_line && clk_en && fail_monitor_en
      && !primary_clock_ok |=> clk_status.rc_osc_select
      && clk_status.clock_fail_event) else $error("no fallback at release");
endmodule : src_reset_combiner_properties
bind src_reset_combiner src_reset_combiner_properties u_props (.core_clk,
   .reset_n, .clk_en, .sources, .cause_wr, .fail_monitor_en,
   .primary_clock_ok, .system_reset_line, .reset_cause_register,
   .clk_status);
`default_nettype wire

// ---- sim/test_src_reset_combiner.sv ----
// Testbench: reset combiner against the clock system model
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
   error_cnt++; $display("wrong value at %0t: got %h expected %h", \
   $time, got, exp); end end
module test_src_reset_combiner
   import src_pkg::*;
;
   typedef struct packed {
      logic [8:0] src;
      logic [9:0] wr;
      logic line;
      logic [8:0] cause;
   } src_row_s;
   logic core_clk = 1'h0;
   logic reset_n = 1'h0;
   logic clk_en = 1'h1;
   src_sources_s sources = '0;
   src_cause_wr_s cause_wr = '0;
   logic retain_wr_en = 1'h0;
   logic [15:0] retain_wr_data = 16'h0000;
   logic fail_monitor_en = 1'h1;
   logic crystal_select_req = 1'h0;
   logic clock_valid, primary_clock_ok, system_reset_line;
   logic [8:0] reset_cause_register;
   logic [8:0] sources_active;
   logic [15:0] retain_rd_data;
   src_clk_status_s clk_status;
   int error_cnt = 0;
   int comparisons = 0;
   int cycles = 0;
   // Row 0 clears the causes after reading, as software should
   src_row_s rows [8] = '{{9'h000, 10'h200, 1'h0, 9'h000},
      {9'h010, 10'h000, 1'h1, 9'h010}, {9'h000, 10'h000, 1'h0, 9'h010},
      {9'h1FC, 10'h000, 1'h1, 9'h1FC}, {9'h000, 10'h2AA, 1'h0, 9'h0AA},
      {9'h004, 10'h200, 1'h1, 9'h004}, {9'h001, 10'h000, 1'h1, 9'h003},
      {9'h000, 10'h3FF, 1'h0, 9'h1FF}};
   src_reset_combiner #(.RETAIN_W(16)) u_src_reset_combiner (.core_clk,
      .reset_n, .clk_en, .sources, .cause_wr, .retain_wr_en,
      .retain_wr_data, .fail_monitor_en, .primary_clock_ok, .clock_valid,
      .crystal_select_req, .system_reset_line, .reset_cause_register,
      .sources_active, .retain_rd_data, .clk_status);
   src_clock_model u_src_clock_model (.core_clk, .reset_n, .clock_valid,
      .primary_clock_ok);
   always #2.5 core_clk = ~core_clk;
   // Hang guard, well above the roughly 90 cycles the run needs
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("comparisons %0d, error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (5) @(negedge core_clk);
      reset_n = 1'h1;
      // Release comes before any clock is ready; the monitor falls back
      repeat (3) @(negedge core_clk);
      `CHK(system_reset_line, 1'h0);
      `CHK({clock_valid, clk_status.fetch_enable}, 2'h0);
      `CHK(clk_status.rc_osc_select, 1'h1);
      for (int i = 0; i < 50 && clk_status.fetch_enable !== 1'h1; i++) begin
         @(negedge core_clk);
      end
      `CHK({clock_valid, clk_status.fetch_enable}, 2'h3);
      // Trap handler returns to the crystal once it runs
      repeat (45) @(negedge core_clk);
      crystal_select_req = 1'h1;
      @(negedge core_clk);
      crystal_select_req = 1'h0;
      `CHK(clk_status.rc_osc_select, 1'h0);
      foreach (rows[i]) begin
         sources = rows[i].src;
         cause_wr = rows[i].wr;
         @(negedge core_clk);
         `CHK(system_reset_line, rows[i].line);
         `CHK(reset_cause_register, rows[i].cause);
         `CHK(sources_active, rows[i].src);
      end
      // Every source alone beats a clearing write in the same cycle
      cause_wr = 10'h200;
      for (int i = 0; i < CAUSE_W; i++) begin
         sources = 9'h001 << i;
         @(negedge core_clk);
         `CHK(reset_cause_register, i == 0 ? 9'h003 : 9'h001 << i);
      end
      cause_wr = '0;
      sources = '0;
      retain_wr_en = 1'h1;
      retain_wr_data = 16'hA5C3;
      @(negedge core_clk);
      retain_wr_en = 1'h0;
      sources = 9'h080;
      repeat (2) @(negedge core_clk);
      `CHK(retain_rd_data, 16'hA5C3);
      sources = '0;
      clk_en = 1'h0;
      repeat (2) @(negedge core_clk);
      `CHK(system_reset_line, 1'h1);
      clk_en = 1'h1;
      // Monitor off: no fallback even though the crystal is not ready
      fail_monitor_en = 1'h0;
      // Power-on in mid-run redefines the causes at once
      reset_n = 1'h0;
      #1;
      `CHK(reset_cause_register, CAUSE_POR_VALUE);
      `CHK(system_reset_line, SYS_RESET_AT_POR);
      @(negedge core_clk);
      reset_n = 1'h1;
      repeat (2) @(negedge core_clk);
      `CHK(system_reset_line, 1'h0);
      `CHK(clk_status.rc_osc_select, 1'h0);
      stop_test();
   end
endmodule : test_src_reset_combiner
`default_nettype wire
